// ### design/protection_event_counters_consts.svh
// Constants for the protection event counter bank.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef PROTECTION_EVENT_COUNTERS_CONSTS_SVH
`define PROTECTION_EVENT_COUNTERS_CONSTS_SVH

// ----------------------------------------------------------------
// Counter counts and widths
// ----------------------------------------------------------------
`define NUM_STAGE_STARTS   6
`define NUM_PHASE_TRIPS    3
`define NUM_OTHER_TRIPS    5
`define NUM_SHOTS          3
`define NUM_SOURCES        4

`define START_WIDTH        10
`define START_MAX          999
`define TRIP_WIDTH         16
`define TRIP_MAX           65535
`define SHOT_WIDTH         8
`define SHOT_MAX           255

// ----------------------------------------------------------------
// Input positions
// ----------------------------------------------------------------
`define START_LOW_SET_OC       0
`define START_HIGH_SET_OC      1
`define START_INST_OC          2
`define START_UNBALANCE        3
`define START_LOW_SET_EF       4
`define START_HIGH_SET_EF      5

`define TRIP_LOW_SET_EF        0
`define TRIP_HIGH_SET_EF       1
`define TRIP_THERMAL           2
`define TRIP_FLASH_FAULT       3
`define TRIP_EXTERNAL          4

// Shot number seen on the shot port for shot 1
`define FIRST_SHOT_NUMBER      2'h1

`endif

// ### design/protection_event_counters_pkg.sv
// Types for the protection event counter bank.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package protection_event_counters_pkg;

    // Initiating source of a reclosing shot
    typedef enum logic [1:0] {
        SRC_HIGH_SET_TRIP,
        SRC_DIGITAL_INPUT,
        SRC_LOW_SET_OC,
        SRC_EARTH_FAULT
    } reclose_source_type;

endpackage

`default_nettype wire

// ### design/event_counter.sv
// One event counter, saturating or wrapping at a set maximum.
// Assumes a one-cycle count pulse and a reset already synchronised.
`timescale 1ns/1ps
`default_nettype none

module event_counter #(
    parameter int WIDTH = 8,
    parameter int MAX   = 255,
    parameter bit WRAP  = 1'h0
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    // Event
    input  wire logic             count_pulse,
    // Result
    output logic [WIDTH-1:0]      count
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (WIDTH < 1 || WIDTH > 31 || MAX < 1 || MAX >= (1 << WIDTH)) begin : g_bad
        $error("event_counter: MAX does not fit WIDTH");
    end

    localparam logic [WIDTH-1:0] MAX_VAL = WIDTH'(MAX);

    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;

    // ------------------------------------------------------------
    // Count
    // ------------------------------------------------------------
    always_comb begin
        count_next = count_reg;
        if (count_pulse) begin
            if (count_reg == MAX_VAL) begin
                count_next = WRAP ? '0 : count_reg;
            end else begin
                count_next = count_reg + WIDTH'(1);
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

    assign count = count_reg;

endmodule

`default_nettype wire

// ### design/protection_event_counters.sv
// Bank of start, trip and reclosing shot counters.
// Assumes event inputs synchronous to clk_sys, held high while active.
`timescale 1ns/1ps
`default_nettype none
`include "protection_event_counters_consts.svh"

module protection_event_counters #(
    parameter int START_MAX = `START_MAX,
    parameter int TRIP_MAX  = `TRIP_MAX,
    parameter int SHOT_MAX  = `SHOT_MAX
) (
    // Clock and reset
    input  wire logic                              clk_sys,
    input  wire logic                              rst_b,
    // Protection stage events, level
    input  wire logic [`NUM_STAGE_STARTS-1:0]      stage_start,
    input  wire logic [`NUM_PHASE_TRIPS-1:0]       phase_trip,
    input  wire logic [`NUM_OTHER_TRIPS-1:0]       other_trip,
    // Reclosing shot event, level, with qualifiers
    input  wire logic                              reclose_init,
    input  wire logic [1:0]                        reclose_shot,
    input  wire logic [1:0]                        reclose_source,
    // Start counts
    output logic [`NUM_STAGE_STARTS-1:0][`START_WIDTH-1:0] start_count,
    // Trip counts
    output logic [`NUM_PHASE_TRIPS-1:0][`TRIP_WIDTH-1:0]   phase_trip_count,
    output logic [`NUM_OTHER_TRIPS-1:0][`TRIP_WIDTH-1:0]   other_trip_count,
    // Shot counts, index shot * 4 + source
    output logic [`NUM_SHOTS*`NUM_SOURCES-1:0][`SHOT_WIDTH-1:0] shot_count
);

    localparam int NUM_LEVELS = `NUM_STAGE_STARTS + `NUM_PHASE_TRIPS
                              + `NUM_OTHER_TRIPS + 1;
    localparam int PHASE_BASE = `NUM_STAGE_STARTS;
    localparam int OTHER_BASE = PHASE_BASE + `NUM_PHASE_TRIPS;
    localparam int INIT_POS   = OTHER_BASE + `NUM_OTHER_TRIPS;
    localparam int NUM_SHOT_CNT = `NUM_SHOTS * `NUM_SOURCES;

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (START_MAX >= (1 << `START_WIDTH) || TRIP_MAX >= (1 << `TRIP_WIDTH)
        || SHOT_MAX >= (1 << `SHOT_WIDTH)) begin : g_bad
        $error("protection_event_counters: maximum exceeds counter width");
    end

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_meta_reg;
    logic rst_meta_next;
    logic rst_sync_reg;
    logic rst_sync_next;
    logic rst_n;

    // Release only; assertion reaches the flops directly
    always_comb begin
        rst_meta_next = 1'h1;
        rst_sync_next = rst_meta_reg;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_reg <= 1'h0;
            rst_sync_reg <= 1'h0;
        end else begin
            rst_meta_reg <= rst_meta_next;
            rst_sync_reg <= rst_sync_next;
        end
    end

    assign rst_n = rst_sync_reg;

    // ------------------------------------------------------------
    // Rising edge detection
    // ------------------------------------------------------------
    logic [NUM_LEVELS-1:0] level_now;
    logic [NUM_LEVELS-1:0] level_reg;
    logic [NUM_LEVELS-1:0] level_next;
    logic [NUM_LEVELS-1:0] rise;

    // Counter order of the event levels
    always_comb begin
        level_now = '0;
        level_now[`START_LOW_SET_OC]  = stage_start[`START_LOW_SET_OC];
        level_now[`START_HIGH_SET_OC] = stage_start[`START_HIGH_SET_OC];
        level_now[`START_INST_OC]     = stage_start[`START_INST_OC];
        level_now[`START_UNBALANCE]   = stage_start[`START_UNBALANCE];
        level_now[`START_LOW_SET_EF]  = stage_start[`START_LOW_SET_EF];
        level_now[`START_HIGH_SET_EF] = stage_start[`START_HIGH_SET_EF];
        level_now[PHASE_BASE +: `NUM_PHASE_TRIPS] = phase_trip;
        level_now[OTHER_BASE + `TRIP_LOW_SET_EF] =
            other_trip[`TRIP_LOW_SET_EF];
        level_now[OTHER_BASE + `TRIP_HIGH_SET_EF] =
            other_trip[`TRIP_HIGH_SET_EF];
        level_now[OTHER_BASE + `TRIP_THERMAL] =
            other_trip[`TRIP_THERMAL];
        level_now[OTHER_BASE + `TRIP_FLASH_FAULT] =
            other_trip[`TRIP_FLASH_FAULT];
        level_now[OTHER_BASE + `TRIP_EXTERNAL] =
            other_trip[`TRIP_EXTERNAL];
        level_now[INIT_POS] = reclose_init;
    end

    always_comb begin
        level_next = level_now;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            level_reg <= '0;
        end else begin
            level_reg <= level_next;
        end
    end

    assign rise = level_now & ~level_reg;

    // ------------------------------------------------------------
    // Start counters
    // ------------------------------------------------------------
    for (genvar i = 0; i < `NUM_STAGE_STARTS; i++) begin : g_start
        event_counter #(
            .WIDTH (`START_WIDTH),
            .MAX   (START_MAX),
            .WRAP  (1'h0)
        ) u_cnt (
            .clk_sys     (clk_sys),
            .rst_n       (rst_n),
            .count_pulse (rise[i]),
            .count       (start_count[i])
        );
    end

    // ------------------------------------------------------------
    // Trip counters
    // ------------------------------------------------------------
    for (genvar i = 0; i < `NUM_PHASE_TRIPS; i++) begin : g_phase_trip
        event_counter #(
            .WIDTH (`TRIP_WIDTH),
            .MAX   (TRIP_MAX),
            .WRAP  (1'h1)
        ) u_cnt (
            .clk_sys     (clk_sys),
            .rst_n       (rst_n),
            .count_pulse (rise[PHASE_BASE+i]),
            .count       (phase_trip_count[i])
        );
    end

    for (genvar i = 0; i < `NUM_OTHER_TRIPS; i++) begin : g_other_trip
        event_counter #(
            .WIDTH (`TRIP_WIDTH),
            .MAX   (TRIP_MAX),
            .WRAP  (1'h1)
        ) u_cnt (
            .clk_sys     (clk_sys),
            .rst_n       (rst_n),
            .count_pulse (rise[OTHER_BASE+i]),
            .count       (other_trip_count[i])
        );
    end

    // ------------------------------------------------------------
    // Reclosing shot counters
    // ------------------------------------------------------------
    protection_event_counters_pkg::reclose_source_type source;
    logic [`NUM_SHOTS-1:0]   shot_sel;
    logic [`NUM_SOURCES-1:0] source_sel;

    assign source = protection_event_counters_pkg::reclose_source_type'(
                        reclose_source);

    // Shot number decode; a zero shot number selects nothing
    always_comb begin
        shot_sel = '0;
        for (int s = 0; s < `NUM_SHOTS; s++) begin
            if (reclose_shot == `FIRST_SHOT_NUMBER + 2'(s)) begin
                shot_sel[s] = 1'h1;
            end
        end
    end

    // Source decode, one counter column per source
    always_comb begin
        source_sel = '0;
        case (source)
            protection_event_counters_pkg::SRC_HIGH_SET_TRIP: begin
                source_sel[0] = 1'h1;
            end
            protection_event_counters_pkg::SRC_DIGITAL_INPUT: begin
                source_sel[1] = 1'h1;
            end
            protection_event_counters_pkg::SRC_LOW_SET_OC: begin
                source_sel[2] = 1'h1;
            end
            protection_event_counters_pkg::SRC_EARTH_FAULT: begin
                source_sel[3] = 1'h1;
            end
            default: begin
                source_sel = '0;
            end
        endcase
    end

    for (genvar i = 0; i < NUM_SHOT_CNT; i++) begin : g_shot
        logic hit;

        // Only the counter of this shot and source moves
        assign hit = rise[INIT_POS]
                     && shot_sel[i / `NUM_SOURCES]
                     && source_sel[i % `NUM_SOURCES];

        event_counter #(
            .WIDTH (`SHOT_WIDTH),
            .MAX   (SHOT_MAX),
            .WRAP  (1'h0)
        ) u_cnt (
            .clk_sys     (clk_sys),
            .rst_n       (rst_n),
            .count_pulse (hit),
            .count       (shot_count[i])
        );
    end

endmodule

`default_nettype wire

// ### bench/event_counters_properties.sv
// Checker for the event counter bank.
// Assumes binding onto protection_event_counters, inputs held off edges.
`timescale 1ns/1ps
`default_nettype none
module event_counters_properties #(
    parameter int START_MAX = 999,
    parameter int TRIP_MAX  = 65535,
    parameter int SHOT_MAX  = 255
) (
    // Clock and reset
    input wire logic             clk_sys,
    input wire logic             rst_b,
    // Events
    input wire logic [5:0]       stage_start,
    input wire logic [2:0]       phase_trip,
    input wire logic [4:0]       other_trip,
    input wire logic             reclose_init,
    input wire logic [1:0]       reclose_shot,
    input wire logic [1:0]       reclose_source,
    // Counts
    input wire logic [5:0][9:0]  start_count,
    input wire logic [2:0][15:0] phase_trip_count,
    input wire logic [4:0][15:0] other_trip_count,
    input wire logic [11:0][7:0] shot_count
);
    logic [7:0]       trips;
    logic [7:0][15:0] tcnt;
    logic [3:0]       idx;
    assign trips = {other_trip, phase_trip};
    assign tcnt  = {other_trip_count, phase_trip_count};
    assign idx   = {reclose_shot - 2'h1, reclose_source};
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    sequence shot_hit(int k);
        $rose(reclose_init) && reclose_shot != 2'h0 && idx == k
            && shot_count[k] < SHOT_MAX;
    endsequence
    for (genvar i = 0; i < 6; i++) begin : g_start
        AST_START_INC: assert property (
            $rose(stage_start[i]) && start_count[i] < START_MAX
            |=> start_count[i] == $past(start_count[i]) + 10'h1)
            else $error("start count did not step");
        AST_START_SAT: assert property (
            start_count[i] == START_MAX |=> $stable(start_count[i]))
            else $error("start count passed its limit");
        AST_START_HOLD: assert property (
            !$rose(stage_start[i]) |=> $stable(start_count[i]))
            else $error("start count moved without an edge");
    end
    for (genvar i = 0; i < 8; i++) begin : g_trip
        AST_TRIP_STEP: assert property (
            $rose(trips[i]) |=> tcnt[i] == ($past(tcnt[i]) == TRIP_MAX
            ? 16'h0 : $past(tcnt[i]) + 16'h1))
            else $error("trip count stepped wrongly");
        AST_TRIP_HOLD: assert property (
            !$rose(trips[i]) |=> $stable(tcnt[i]))
            else $error("trip count moved without an edge");
    end
    for (genvar k = 0; k < 12; k++) begin : g_shot
        AST_SHOT_INC: assert property (
            shot_hit(k) |=> shot_count[k] == $past(shot_count[k]) + 8'h1)
            else $error("shot count did not step");
        AST_SHOT_SAT: assert property (
            shot_count[k] == SHOT_MAX |=> $stable(shot_count[k]))
            else $error("shot count passed its limit");
        AST_SHOT_ONLY: assert property (
            !($rose(reclose_init) && reclose_shot != 2'h0 && idx == k)
            |=> $stable(shot_count[k]))
            else $error("shot count moved for another shot");
    end
endmodule
bind protection_event_counters event_counters_properties #(
    .START_MAX(START_MAX), .TRIP_MAX(TRIP_MAX), .SHOT_MAX(SHOT_MAX)
) u_props (
    .clk_sys(clk_sys), .rst_b(rst_b), .stage_start(stage_start),
    .phase_trip(phase_trip), .other_trip(other_trip),
    .reclose_init(reclose_init), .reclose_shot(reclose_shot),
    .reclose_source(reclose_source), .start_count(start_count),
    .phase_trip_count(phase_trip_count),
    .other_trip_count(other_trip_count), .shot_count(shot_count)
);
`default_nettype wire

// ### bench/event_source.sv
// Stand-in for the protection stages and reclosing logic.
// Assumes a new event pattern from the bench each cycle.
`timescale 1ns/1ps
`default_nettype none
module event_source (
    // Clock
    input  wire logic        clk_sys,
    // Wanted pattern
    input  wire logic [18:0] req,
    // Events
    output logic [5:0]       stage_start,
    output logic [2:0]       phase_trip,
    output logic [4:0]       other_trip,
    output logic             reclose_init,
    output logic [1:0]       reclose_shot,
    output logic [1:0]       reclose_source
);
    // Qualifiers churn even while no shot starts
    always @(negedge clk_sys) begin
        {reclose_source, reclose_shot, reclose_init, other_trip,
            phase_trip, stage_start} <= req;
    end
endmodule
`default_nettype wire

// ### bench/tb_top.sv
// Random event bench for the counter bank.
// Assumes the partner applies each pattern at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int MAXV = 5;
    logic             clk_sys = 1'h0;
    logic             rst_b = 1'h0;
    logic [18:0]      req = 19'h0;
    logic [5:0]       ss;
    logic [2:0]       pt;
    logic [4:0]       ot;
    logic             ri;
    logic [1:0]       rs;
    logic [1:0]       rc;
    logic [5:0][9:0]  sc;
    logic [2:0][15:0] pc;
    logic [4:0][15:0] oc;
    logic [11:0][7:0] hc;
    logic [283:0]     exp_q[$];
    logic [5:0][9:0]  e_s = '0;
    logic [7:0][15:0] e_t = '0;
    logic [11:0][7:0] e_h = '0;
    logic [13:0]      prev = 14'h0;
    logic             prev_init = 1'h0;
    int miscompares = 0;
    int samples_checked = 0;
    int seed = 368;
    always #10 clk_sys = ~clk_sys;
    event_source u_src (.clk_sys(clk_sys), .req(req), .stage_start(ss),
        .phase_trip(pt), .other_trip(ot), .reclose_init(ri),
        .reclose_shot(rs), .reclose_source(rc));
    protection_event_counters #(.START_MAX(MAXV), .TRIP_MAX(MAXV),
        .SHOT_MAX(MAXV)) dut (.clk_sys(clk_sys), .rst_b(rst_b),
        .stage_start(ss), .phase_trip(pt), .other_trip(ot),
        .reclose_init(ri), .reclose_shot(rs), .reclose_source(rc),
        .start_count(sc), .phase_trip_count(pc),
        .other_trip_count(oc), .shot_count(hc));
    task automatic check(input logic [283:0] seen, input logic [283:0] want);
        samples_checked++;
        if (seen !== want) begin
            miscompares++;
            $display("wrong value at %0t: counts %h", $time, seen);
        end
    endtask
    task automatic finish_test();
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Expected counts from the levels the design samples now
    task automatic note();
        logic [13:0] ev;
        logic [3:0]  k;
        ev = {ot, pt, ss};
        k = {rs - 2'h1, rc};
        for (int i = 0; i < 6; i++)
            if (ev[i] && !prev[i] && e_s[i] < MAXV)
                e_s[i] = e_s[i] + 10'h1;
        for (int j = 0; j < 8; j++)
            if (ev[j+6] && !prev[j+6])
                e_t[j] = (e_t[j] == MAXV) ? 16'h0 : e_t[j] + 16'h1;
        if (ri && !prev_init && rs != 2'h0 && e_h[k] < MAXV)
            e_h[k] = e_h[k] + 8'h1;
        prev = ev;
        prev_init = ri;
        exp_q.push_back({e_s, e_t, e_h});
    endtask
    always @(posedge clk_sys) begin
        #1;
        if (exp_q.size() > 0)
            check({sc, oc, pc, hc}, exp_q.pop_front());
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys) rst_b = 1'h1;
        repeat (4) @(posedge clk_sys);
        repeat (900) begin
            @(posedge clk_sys);
            note();
            #2 req = 19'($random(seed));
        end
        @(posedge clk_sys);
        note();
        @(negedge clk_sys);
        finish_test();
    end
    initial begin
        #40000;
        miscompares++;
        finish_test();
    end
endmodule
`default_nettype wire
